// *** uvp_defs.svh ***
// constants of the undervoltage protection stage: offsets, fields, resets
`ifndef UVP_DEFS_SVH
`define UVP_DEFS_SVH

`define UVP_STAGES 4
`define UVP_GROUPS 8
`define UVP_KINDS 3
`define UVP_ADDR_W 10

`define UVP_REG_CTRL 10'h000
`define UVP_REG_CMD 10'h004
`define UVP_REG_STATUS 10'h008
`define UVP_REG_GEN 10'h010
`define UVP_REG_PREF 10'h020
`define UVP_REG_CNT 10'h040
`define UVP_REG_SET 10'h100
`define UVP_GEN_MASK 10'h3F0
`define UVP_PREF_MASK 10'h3F0
`define UVP_CNT_MASK 10'h3C0
`define UVP_SET_MASK 10'h300

`define UVP_CTRL_TWO_LINE 0
`define UVP_CTRL_FORCE_EN 1
`define UVP_CMD_CLR_CNT 0
`define UVP_GEN_MSEL 1:0
`define UVP_GEN_FORCE 3:2
`define UVP_SETA_PICKUP 15:0
`define UVP_SETA_BLOCK 31:16
`define UVP_SETB_DELAY 15:0
`define UVP_SETB_DIAL 30:16
`define UVP_SETB_INV 31

`define UVP_CTRL_RST 32'h0000_0000
`define UVP_GEN_RST 32'h0000_0000
`define UVP_SETA_RST 32'h0064_0258
`define UVP_SETB_RST 32'h000A_0008

`define UVP_CLK_PERIOD_NS 25
`define UVP_MS_NS 1000000
`define UVP_SAMPLE_MS 5
`define UVP_PREFAULT_MS 20
`define UVP_HYST_PCT 103
`define UVP_PCT_FULL 100

`endif

// *** uvp_pkg.sv ***
// types shared by the undervoltage protection stage files
`default_nettype none
package uvp_pkg;
   typedef enum logic [1:0] {
      uvp_sel_pp = 2'b00,
      uvp_sel_pe = 2'b01,
      uvp_sel_ch3 = 2'b10,
      uvp_sel_ch4 = 2'b11
   } uvp_msel_t;
   typedef enum logic [1:0] {
      uvp_frc_normal = 2'b00,
      uvp_frc_start = 2'b01,
      uvp_frc_trip = 2'b10,
      uvp_frc_blocked = 2'b11
   } uvp_force_t;
endpackage
`default_nettype wire

// *** uvp_stage.sv ***
// one undervoltage stage: pick-up, blocking, delay timer, forced status
`include "uvp_defs.svh"
`default_nettype none
module uvp_stage (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic [47:0] mag,
   input wire logic [2:0] mask,
   input wire logic [15:0] pickup,
   input wire logic [15:0] blk_level,
   input wire logic inv_mode,
   input wire logic [15:0] delay_ticks,
   input wire logic [14:0] dial,
   input wire logic ext_blk,
   input wire logic force_en,
   input wire uvp_pkg::uvp_force_t force_code,
   output logic start,
   output logic trip,
   output logic blocked,
   output logic [15:0] sup_mag
);
   logic [2:0] below, above_hys, under_blk, above_pu;
   logic pick, iblk, st_int, tr_int, bl_int;
   logic [15:0] cnt;
   logic [31:0] acc;
   logic next_pick, next_iblk, blocking, run, next_trip;
   logic [15:0] next_cnt;
   logic [31:0] next_acc;
   logic [31:0] dial_lim;
   logic [15:0] deficit;

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_cmp
         wire [15:0] m = mag[16*i +: 16];
         wire [31:0] m_pct = 32'(m) * 32'(`UVP_PCT_FULL);
         wire [31:0] p_pct = 32'(pickup) * 32'(`UVP_HYST_PCT);
         // see R20
         assign below[i] = mask[i] && (m < pickup);
         // hysteresis scales the pick-up by 103 percent, the measurement by 100; see R17
         assign above_hys[i] = !mask[i] || (m_pct >= p_pct);
         assign under_blk[i] = mask[i] && (m < blk_level);
         assign above_pu[i] = !mask[i] || (m > pickup);
      end
   endgenerate

   always_comb begin
      sup_mag = 16'hFFFF;
      for (int k = 0; k < 3; k++) begin
         if (mask[k] && (mag[16*k +: 16] < sup_mag)) begin
            sup_mag = mag[16*k +: 16];
         end
      end
   end

   assign next_pick = (|below) ? 1'b1 : ((&above_hys) ? 1'b0 : pick);
   // zero level switches the low-voltage latch off; see R18
   // once latched it holds until every voltage clears pick-up; see R19
   assign next_iblk = (blk_level == 16'h0000) ? 1'b0 :
                      (|under_blk) ? 1'b1 :
                      (&above_pu) ? 1'b0 : iblk;
   // two blocking sources; see R03
   assign blocking = next_iblk || ext_blk;
   // start only while unblocked; see R20
   assign run = next_pick && !blocking;
   assign next_cnt = run ? ((cnt == 16'hFFFF) ? cnt : cnt + 16'h0001)
                         : 16'h0000;
   assign deficit = (pickup > sup_mag) ? pickup - sup_mag : 16'h0000;
   assign next_acc = run ? acc + 32'(deficit) : 32'h0000_0000;
   assign dial_lim = 32'(dial) * 32'(pickup);
   // zero delay trips on the start tick itself; see R06
   assign next_trip = run && (tr_int || (inv_mode ? (next_acc >= dial_lim)
                                              : (next_cnt > delay_ticks)));

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pick <= 1'b0;
         iblk <= 1'b0;
         cnt <= 16'h0000;
         acc <= 32'h0000_0000;
         st_int <= 1'b0;
         tr_int <= 1'b0;
         bl_int <= 1'b0;
      end else if (tick) begin
         pick <= next_pick;
         iblk <= next_iblk;
         cnt <= next_cnt;
         acc <= next_acc;
         st_int <= run;
         tr_int <= next_trip;
         bl_int <= next_pick && blocking;
      end
   end

   // forcing is honoured only while the device-wide test mode is on; see R16
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         start <= 1'b0;
         trip <= 1'b0;
         blocked <= 1'b0;
      end else if (force_en && force_code != uvp_pkg::uvp_frc_normal) begin
         start <= (force_code == uvp_pkg::uvp_frc_start) ||
                  (force_code == uvp_pkg::uvp_frc_trip);
         trip <= (force_code == uvp_pkg::uvp_frc_trip);
         blocked <= (force_code == uvp_pkg::uvp_frc_blocked);
      end else begin
         start <= st_int;
         trip <= tr_int;
         blocked <= bl_int;
      end
   end
endmodule
`default_nettype wire

// *** uvp_top.sv ***
// four undervoltage stages with settings, events, counters and register port
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "uvp_defs.svh"
`default_nettype none
// Operation
// R01 - four independent stages, own outputs and counters
// R02 - magnitude select: line, phase, ch3, ch4
// R03 - internal low-voltage and external blocking sources
// R04 - eight setting groups, one common selector
// R05 - group or block changes apply while running
// R06 - instant, definite or inverse delayed operation
// R07 - on/off events for start, trip, blocked
// R08 - instant start and trip share stamp
// R09 - event stamps counted in milliseconds
// R10 - clearable start, trip, blocked counters
// R11 - six rms magnitudes on 5 ms base
// R12 - pre-fault 20 ms average ending -20 ms
// R13 - line/phase use three or two channels
// R14 - ch4 always; ch3 only two-line mode
// R15 - general settings static, outside groups
// R16 - force status only in forcing mode
// R17 - reset hysteresis 103 percent of pick-up
// R18 - zero block level disables internal block
// R19 - internal block holds until voltages recover
// R20 - pick-up below threshold, start if unblocked
module uvp_top #(
   parameter int MS_CYCLES = `UVP_MS_NS / `UVP_CLK_PERIOD_NS
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [`UVP_ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic meas_valid,
   input wire logic [47:0] ll_rms,
   input wire logic [47:0] ln_rms,
   input wire logic [15:0] ch3_rms,
   input wire logic [15:0] ch4_rms,
   input wire logic [3:0] ext_block_raw,
   input wire logic [2:0] group_sel_raw,
   output logic [3:0] start,
   output logic [3:0] trip,
   output logic [3:0] blocked,
   output logic [11:0] evt_on,
   output logic [11:0] evt_off,
   output logic [31:0] evt_stamp,
   output logic [63:0] prefault
);
   localparam int NS = `UVP_STAGES;
   localparam int NEV = `UVP_STAGES * `UVP_KINDS;
   localparam int PF_N = `UVP_PREFAULT_MS / `UVP_SAMPLE_MS;
   localparam int HIST = 2 * PF_N;

   // synchronisers for the external blocking matrix and group selector
   logic [3:0] blk_s1, blk_s2;
   logic [2:0] grp_s1, grp_s2;
   logic [2:0] grp_s3, grp_ok;

   // control, general, setting-bank and counter registers
   logic [31:0] ctrl;
   logic [31:0] gen [NS];
   logic [31:0] set_a [NS*`UVP_GROUPS];
   logic [31:0] set_b [NS*`UVP_GROUPS];
   logic [15:0] counter [NEV];

   // millisecond time base
   logic [31:0] ms_div;
   logic [31:0] stamp;

   logic [11:0] cur, prev;
   logic [15:0] sup [NS];
   logic [15:0] pf_word [NS];
   logic [31:0] next_rdata;

   // ------------------------------------------------------------ decode
   wire two_line = ctrl[`UVP_CTRL_TWO_LINE];
   wire force_en = ctrl[`UVP_CTRL_FORCE_EN];
   wire wr_ctrl = wr && (addr == `UVP_REG_CTRL);
   wire wr_cmd = wr && (addr == `UVP_REG_CMD);
   wire clr_cnt = wr_cmd && wdata[`UVP_CMD_CLR_CNT];
   wire in_gen = ((addr & `UVP_GEN_MASK) == `UVP_REG_GEN);
   wire in_pref = ((addr & `UVP_PREF_MASK) == `UVP_REG_PREF);
   wire in_cnt = ((addr & `UVP_CNT_MASK) == `UVP_REG_CNT);
   wire in_set = ((addr & `UVP_SET_MASK) == `UVP_REG_SET);
   wire [1:0] gen_idx = addr[3:2];
   wire [3:0] cnt_idx = addr[5:2];
   wire [4:0] set_idx = addr[7:3];
   wire set_is_b = addr[2];
   wire wr_gen = wr && in_gen;
   wire wr_set_a = wr && in_set && !set_is_b;
   wire wr_set_b = wr && in_set && set_is_b;
   wire ms_tick = (ms_div == 32'(MS_CYCLES - 1));

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         blk_s1 <= 4'h0;
         blk_s2 <= 4'h0;
         grp_s1 <= 3'h0;
         grp_s2 <= 3'h0;
      end else begin
         blk_s1 <= ext_block_raw;
         blk_s2 <= blk_s1;
         grp_s1 <= group_sel_raw;
         grp_s2 <= grp_s1;
      end
   end

   // a group code whose bits land on different edges could name a bank
   // nobody chose for a cycle; take it only once two samples agree
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         grp_s3 <= 3'h0;
         grp_ok <= 3'h0;
      end else begin
         grp_s3 <= grp_s2;
         if (grp_s2 == grp_s3) begin
            grp_ok <= grp_s3;
         end
      end
   end

   // time stamps tick once per millisecond; see R09
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ms_div <= 32'h0000_0000;
         stamp <= 32'h0000_0000;
      end else if (ms_tick) begin
         ms_div <= 32'h0000_0000;
         stamp <= stamp + 32'h0000_0001;
      end else begin
         ms_div <= ms_div + 32'h0000_0001;
      end
   end

   // general settings live outside the group banks; see R15
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= `UVP_CTRL_RST;
         for (int s = 0; s < NS; s++) begin
            gen[s] <= `UVP_GEN_RST;
         end
      end else begin
         if (wr_ctrl) begin
            ctrl <= wdata & 32'h0000_0003;
         end
         if (wr_gen) begin
            gen[gen_idx] <= wdata & 32'h0000_000F;
         end
      end
   end

   // eight banks per stage, written at any time; see R04
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int j = 0; j < NS*`UVP_GROUPS; j++) begin
            set_a[j] <= `UVP_SETA_RST;
            set_b[j] <= `UVP_SETB_RST;
         end
      end else begin
         if (wr_set_a) begin
            set_a[set_idx] <= wdata;
         end
         if (wr_set_b) begin
            set_b[set_idx] <= wdata;
         end
      end
   end

   // ------------------------------------------------------------ stages
   genvar s;
   generate
      // one stage instance each; see R01
      for (s = 0; s < NS; s++) begin : g_stage
         logic [47:0] mag;
         logic [2:0] mask;
         logic [15:0] hist [HIST];
         logic [17:0] pf_sum;
         logic [15:0] pf_hold;
         logic sv, tv, bv, sv_q, tv_q;
         uvp_pkg::uvp_msel_t msel;
         // group taken live from the common selector; see R05
         wire [4:0] bank = {2'(s), grp_ok};
         wire [31:0] wa = set_a[bank];
         wire [31:0] wb = set_b[bank];

         assign msel = uvp_pkg::uvp_msel_t'(gen[s][`UVP_GEN_MSEL]);

         // channel selection per connection mode; see R02
         always_comb begin
            mag = 48'h0000_0000_0000;
            mask = 3'b000;
            unique case (msel)
               uvp_pkg::uvp_sel_pp: begin
                  mag = ll_rms;
                  // two-line mode drops the third channel; see R13
                  mask = two_line ? 3'b011 : 3'b111;
               end
               uvp_pkg::uvp_sel_pe: begin
                  mag = ln_rms;
                  mask = two_line ? 3'b011 : 3'b111;
               end
               uvp_pkg::uvp_sel_ch3: begin
                  mag = {32'h0000_0000, ch3_rms};
                  // ch3 is only supervised in two-line mode; see R14
                  mask = two_line ? 3'b001 : 3'b000;
               end
               uvp_pkg::uvp_sel_ch4: begin
                  mag = {32'h0000_0000, ch4_rms};
                  mask = 3'b001;
               end
            endcase
         end

         // magnitudes are consumed on the 5 ms sample strobe; see R11
         uvp_stage u_stage (
            .mclk(mclk),
            .nrst(nrst),
            .tick(meas_valid),
            .mag(mag),
            .mask(mask),
            .pickup(wa[`UVP_SETA_PICKUP]),
            .blk_level(wa[`UVP_SETA_BLOCK]),
            .inv_mode(wb[`UVP_SETB_INV]),
            .delay_ticks(wb[`UVP_SETB_DELAY]),
            .dial(wb[`UVP_SETB_DIAL]),
            .ext_blk(blk_s2[s]),
            .force_en(force_en),
            .force_code(uvp_pkg::uvp_force_t'(gen[s][`UVP_GEN_FORCE])),
            .start(sv),
            .trip(tv),
            .blocked(bv),
            .sup_mag(sup[s])
         );

         // history of the supervised value; oldest half feeds pre-fault
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               for (int h = 0; h < HIST; h++) begin
                  hist[h] <= 16'h0000;
               end
            end else if (meas_valid) begin
               hist[0] <= sup[s];
               for (int h = 1; h < HIST; h++) begin
                  hist[h] <= hist[h-1];
               end
            end
         end

         always_comb begin
            pf_sum = 18'h0_0000;
            for (int h = PF_N; h < HIST; h++) begin
               pf_sum = pf_sum + 18'(hist[h]);
            end
         end

         // average of the window that ends 20 ms before the event; see R12
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               pf_hold <= 16'h0000;
               sv_q <= 1'b0;
               tv_q <= 1'b0;
            end else begin
               sv_q <= sv;
               tv_q <= tv;
               if ((sv && !sv_q) || (tv && !tv_q)) begin
                  pf_hold <= pf_sum[17:2];
               end
            end
         end

         assign pf_word[s] = pf_hold;
         assign prefault[16*s +: 16] = pf_hold;
         assign start[s] = sv;
         assign trip[s] = tv;
         assign blocked[s] = bv;
         assign cur[3*s] = sv;
         assign cur[3*s+1] = tv;
         assign cur[3*s+2] = bv;
      end
   endgenerate

   // ------------------------------------------------------------ events
   // edges of all twelve outputs leave together with one stamp; see R07
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prev <= 12'h000;
         evt_on <= 12'h000;
         evt_off <= 12'h000;
         evt_stamp <= 32'h0000_0000;
      end else begin
         prev <= cur;
         evt_on <= cur & ~prev;
         evt_off <= prev & ~cur;
         // start and trip rising together carry the same stamp; see R08
         if (|(cur ^ prev)) begin
            evt_stamp <= stamp;
         end
      end
   end

   // a clear in the same cycle as an event leaves a count of one; see R10
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int e = 0; e < NEV; e++) begin
            counter[e] <= 16'h0000;
         end
      end else begin
         for (int e = 0; e < NEV; e++) begin
            if (evt_on[e]) begin
               counter[e] <= clr_cnt ? 16'h0001 : counter[e] + 16'h0001;
            end else if (clr_cnt) begin
               counter[e] <= 16'h0000;
            end
         end
      end
   end

   // ------------------------------------------------------------ readback
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (addr == `UVP_REG_CTRL) begin
         next_rdata = ctrl;
      end else if (addr == `UVP_REG_STATUS) begin
         next_rdata = {17'h0_0000, grp_ok, cur};
      end else if (in_gen) begin
         next_rdata = gen[gen_idx];
      end else if (in_pref) begin
         next_rdata = {16'h0000, pf_word[gen_idx]};
      end else if (in_cnt && (cnt_idx < 4'(NEV))) begin
         next_rdata = {16'h0000, counter[cnt_idx]};
      end else if (in_set) begin
         next_rdata = set_is_b ? set_b[set_idx] : set_a[set_idx];
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rd ? next_rdata : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// *** uvp_assertions.sv ***
// port-level assertions for the undervoltage stages, bound to the top
`default_nettype none
module uvp_checker (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [3:0] start,
   input wire logic [3:0] trip,
   input wire logic [3:0] blocked,
   input wire logic [11:0] evt_on,
   input wire logic [11:0] evt_off,
   input wire logic [31:0] evt_stamp
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   for (genvar s = 0; s < 4; s++) begin : g_st
      chk_start_on_evt: assert property ($rose(start[s]) |=> evt_on[3*s])
         else $error("start rose, no on event");
      chk_trip_on_evt: assert property ($rose(trip[s]) |=> evt_on[3*s+1])
         else $error("trip rose, no on event");
      chk_start_off_evt: assert property ($fell(start[s]) |=> evt_off[3*s])
         else $error("start fell, no off event");
      chk_blk_off_evt: assert property ($fell(blocked[s]) |=> evt_off[3*s+2])
         else $error("blocked fell, no off event");
      chk_evt_has_cause: assert property (evt_on[3*s] |->
         $past(start[s]) && !$past(start[s], 2))
         else $error("start on event without a rise");
      chk_start_unblocked: assert property (!(start[s] && blocked[s]))
         else $error("start and blocked together");
   end
   chk_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   chk_stamp_held: assert property ((evt_on == 0 && evt_off == 0)
      |-> $stable(evt_stamp))
      else $error("stamp moved without event");
   cov_trip: cover property ($rose(trip[0]));
   cov_blocked: cover property ($rose(blocked[0]));
   cov_instant: cover property (evt_on[3] && evt_on[4]);
endmodule
bind uvp_top uvp_checker chk_u (.mclk, .nrst, .rd, .rdata, .start, .trip,
   .blocked, .evt_on, .evt_off, .evt_stamp);
`default_nettype wire

// *** uvp_meas_model.sv ***
// measurement front end model: rms values that move only with the strobe or in reset
`default_nettype none
module uvp_meas_model #(
   parameter int SAMPLE_CYC = 50
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0][15:0] lvl,
   output logic meas_valid,
   output logic [47:0] ll_rms,
   output logic [47:0] ln_rms,
   output logic [15:0] ch3_rms,
   output logic [15:0] ch4_rms
);
   int cnt;
   wire logic tick = cnt == SAMPLE_CYC - 1;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         meas_valid <= 1'b0;
      end else begin
         cnt <= tick ? 0 : cnt + 1;
         meas_valid <= tick;
      end
   end
   // values are also loaded in reset so the stage never sees unknowns
   always_ff @(posedge mclk) begin
      if (tick || !nrst) begin
         ll_rms <= lvl[2:0];
         ln_rms <= lvl[5:3];
         ch3_rms <= lvl[6];
         ch4_rms <= lvl[7];
      end
   end
endmodule
`default_nettype wire

// *** tb_uvp_top.sv ***
// self-checking bench for the four undervoltage stages
`default_nettype none
module tb_uvp_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MSC = 10;
   localparam logic [15:0] NOM = 16'h03E8;
   localparam logic [15:0] LOW = 16'h01F4;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [9:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] ext = '0;
   logic [2:0] grp = '0;
   logic [7:0][15:0] v = {8{NOM}};
   logic [31:0] rdata, evt_stamp;
   logic [47:0] ll, ln;
   logic [15:0] c3, c4;
   logic mv;
   logic [3:0] start, trip, blocked;
   logic [11:0] evt_on, evt_off;
   logic [63:0] prefault;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   uvp_meas_model #(.SAMPLE_CYC(5 * MSC)) mdl_u (.mclk, .nrst, .lvl(v),
      .meas_valid(mv), .ll_rms(ll), .ln_rms(ln), .ch3_rms(c3), .ch4_rms(c4));
   uvp_top #(.MS_CYCLES(MSC)) dut_u (.mclk, .nrst, .addr, .wdata, .wr, .rd,
      .rdata, .meas_valid(mv), .ll_rms(ll), .ln_rms(ln), .ch3_rms(c3),
      .ch4_rms(c4), .ext_block_raw(ext), .group_sel_raw(grp), .start,
      .trip, .blocked, .evt_on, .evt_off, .evt_stamp, .prefault);
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (nrst) cyc++;
   end
   task automatic check(input string w, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [31:0] x);
      @(posedge mclk);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input string w, input logic [9:0] a, logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      check(w, rdata, e);
   endtask
   // wait n samples, then let outputs and events settle
   task automatic samp(input int n);
      repeat (n) @(posedge mclk iff mv);
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      rchk("ctrl", 10'h000, 32'h0000_0000);
      rchk("gen0", 10'h010, 32'h0000_0000);
      rchk("seta0", 10'h100, 32'h0064_0258);
      rchk("seta7", 10'h1F8, 32'h0064_0258);
      rchk("setb0", 10'h104, 32'h000A_0008);
      wr_reg(10'h3FC, 32'hFFFF_FFFF);
      rchk("unmapped", 10'h3FC, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_dt;
      samp(9);
      v[0] <= LOW;
      samp(1);
      check("start", start, 4'hF);
      check("pref", prefault[15:0], NOM);
      samp(7);
      check("trip early", trip[0], 1'b0);
      samp(3);
      check("trip", trip[0], 1'b1);
      v[0] <= 16'h0262;
      samp(2);
      check("hyst hold", start, 4'hF);
      v[0] <= 16'h026A;
      samp(2);
      check("hyst rel", start, 4'h0);
      rchk("cnt start", 10'h040, 32'h0000_0001);
      rchk("cnt trip", 10'h044, 32'h0000_0001);
      rchk("cnt stage3", 10'h064, 32'h0000_0001);
      wr_reg(10'h004, 32'h0000_0001);
      rchk("cnt clr", 10'h040, 32'h0000_0000);
      $display("test definite delay done");
   endtask
   task automatic t_inst;
      int e;
      wr_reg(10'h144, 32'h0000_0000);
      v[0] <= LOW;
      @(posedge mclk iff mv);
      repeat (2) @(posedge mclk);
      #1;
      e = cyc / MSC;
      check("inst evt", evt_on[4:3], 2'h3);
      check("stamp", evt_stamp + 1 >= e && evt_stamp <= e + 1, 1'b1);
      v[0] <= NOM;
      samp(2);
      $display("test instant done");
   endtask
   task automatic t_block;
      wr_reg(10'h180, 32'h0000_0258);
      ext <= 4'h8;
      v[2:0] <= {3{16'h0032}};
      samp(2);
      check("blk low", blocked, 4'hB);
      check("blk zero", start, 4'h4);
      v[2:0] <= {3{LOW}};
      samp(2);
      check("blk hold", blocked, 4'hB);
      @(posedge mclk);
      v[2:0] <= {3{NOM}};
      ext <= 4'h0;
      samp(2);
      check("blk clr", blocked, 4'h0);
      $display("test blocking done");
   endtask
   task automatic msel_step(input logic [1:0] m, logic tl, int lo, logic e);
      logic [7:0][15:0] t;
      t = {8{NOM}};
      t[lo] = LOW;
      wr_reg(10'h000, {31'h0000_0000, tl});
      wr_reg(10'h010, {30'h0000_0000, m});
      v <= t;
      samp(2);
      check("msel", start[0], e);
   endtask
   task automatic t_msel;
      msel_step(2'h1, 1'b0, 4, 1'b1);
      msel_step(2'h3, 1'b0, 7, 1'b1);
      msel_step(2'h2, 1'b0, 6, 1'b0);
      msel_step(2'h2, 1'b1, 6, 1'b1);
      msel_step(2'h0, 1'b1, 2, 1'b0);
      msel_step(2'h0, 1'b0, 2, 1'b1);
      $display("test selection done");
   endtask
   task automatic t_force;
      wr_reg(10'h010, 32'h0000_0008);
      v <= {8{NOM}};
      samp(2);
      check("no force", trip, 4'h0);
      wr_reg(10'h000, 32'h0000_0002);
      for (int f = 1; f < 4; f++) begin
         wr_reg(10'h010, 32'(f) << 2);
         repeat (3) @(posedge mclk);
         #1;
         check("force", {blocked[0], trip[0], start[0]},
            f == 3 ? 3'h4 : (f == 2 ? 3'h3 : 3'h1));
      end
      wr_reg(10'h010, 32'h0000_0000);
      wr_reg(10'h000, 32'h0000_0000);
      samp(2);
      check("unforced", start[0], 1'b0);
      $display("test forcing done");
   endtask
   task automatic t_group;
      wr_reg(10'h128, 32'h0064_0400);
      wr_reg(10'h010, 32'h0000_0001);
      grp <= 3'h5;
      samp(2);
      check("grp start", start[0], 1'b1);
      rchk("grp stat", 10'h008, 32'h0000_5001);
      rchk("gen static", 10'h010, 32'h0000_0001);
      @(posedge mclk);
      grp <= 3'h0;
      samp(2);
      check("grp back", start[0], 1'b0);
      $display("test groups done");
   endtask
   // dial 1, pick-up 600, deficit 100 a sample: trips on the sixth sample
   task automatic t_inverse_delay_mode;
      wr_reg(10'h104, 32'h8001_0000);
      v[3] <= LOW;
      samp(5);
      check("inverse_delay_mode start", start[0], 1'b1);
      check("inverse_delay_mode early", trip[0], 1'b0);
      samp(1);
      check("inverse_delay_mode trip", trip[0], 1'b1);
      v[3] <= NOM;
      samp(2);
      check("inverse_delay_mode rel", trip[0], 1'b0);
      $display("test inverse delay done");
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      t_reset;
      t_dt;
      t_inst;
      t_block;
      t_msel;
      t_force;
      t_group;
      t_inverse_delay_mode;
      test_done;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      test_done;
   end
endmodule
`default_nettype wire
